// ==== verilog/psc_consts.svh ====
// offsets, field positions, reset values and limits of the patrol scrub control block
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
`define PSC_OFF_ADDR 12'h900
`define PSC_OFF_ROUTE 12'h0B4
`define PSC_OFF_CTRL 12'h914
`define PSC_OFF_SPARE 12'h91C
`define PSC_OFF_RAS 12'h920
`define PSC_B_EN 31
`define PSC_B_STOP_CMPL 30
`define PSC_B_CMPL 29
`define PSC_B_STOP_ERR 28
`define PSC_B_STOPPED 27
`define PSC_B_ISSUED 26
`define PSC_B_ONCE 25
`define PSC_B_START 24
`define PSC_F_IVL_HI 23
`define PSC_F_SPR_HI 28
`define PSC_F_SPR_LO 16
`define PSC_F_NRM_HI 15
`define PSC_B_PIN 17
`define PSC_B_CMCI 16
`define PSC_B_SMI 15
`define PSC_B_MIRROR 0
`define PSC_RST_SPARE_LEN 13'h0320
`define PSC_RST_NORMAL_LEN 16'h0C80
`define PSC_MIN_INTERVAL 24'h0005DC
`endif

// ==== verilog/psc_pkg.sv ====
// types shared by the patrol scrub control block
package psc_pkg;
  typedef enum logic [2:0] {
    st_idle, st_count, st_wait, st_halt_cmpl, st_halt_err, st_once
  } psc_state_t;
endpackage : psc_pkg

// ==== verilog/psc_interval_timer.sv ====
// down-counter that spaces patrol scrub requests
`timescale 1ns/1ps
module psc_interval_timer #(
  parameter int W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [W-1:0] load,
  output logic expired
);
  logic [W-1:0] cnt;

  // a restart in the issue cycle makes the next expiry exactly load cycles later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (restart) begin
      cnt <= load - {{(W-1){1'b0}}, 1'b1};
    end else if (cnt != '0) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expired <= 1'b1;
    end else if (restart) begin
      expired <= (load <= {{(W-1){1'b0}}, 1'b1});
    end else begin
      expired <= (cnt <= {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule : psc_interval_timer

// ==== verilog/psc_phase_alternator.sv ====
// alternates normal traffic and sparing copy phases while a spare copy runs
`timescale 1ns/1ps
module psc_phase_alternator #(
  parameter int SW = 13,
  parameter int NW = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spare_active,
  input wire logic [SW-1:0] spare_len,
  input wire logic [NW-1:0] normal_len,
  output logic block_sys
);
  logic [NW-1:0] cnt;
  logic [NW-1:0] limit;

  assign limit = block_sys ? NW'(spare_len) : normal_len;

  // each spare copy begins with the normal phase so the system is never starved at start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      block_sys <= 1'b0;
    end else if (!spare_active) begin
      cnt <= '0;
      block_sys <= 1'b0;
    end else if (cnt + NW'(1) >= limit) begin
      cnt <= '0;
      block_sys <= !block_sys;
    end else begin
      cnt <= cnt + NW'(1);
    end
  end
endmodule : psc_phase_alternator

// ==== verilog/psc_patrol_scrub_control.sv ====
// patrol scrub engine with its control registers, sparing phases and interrupt routing
// How it works
// - patrol requests are generated only while scrub enable is set
// - stop-at-end mode halts at range end and sets range-complete
// - clearing range-complete or stop-at-end restarts from address zero if enabled
// - stop-on-error logs a poisoned response and halts
// - stop-on-error converts uncorrectable to poison when enabled, then halts
// - an error halt sets the patrol-stopped bit
// - clearing patrol-stopped or stop-on-error resumes at the next address
// - scrub-issued set means the address register holds the last issued address
// - issue-once scrubs the programmed address one time, then stops
// - start-from-address begins at the programmed address, cleared once issued
// - consecutive requests are spaced by the 24-bit interval in clocks
// - during the sparing phase system requests are blocked
// - during the normal phase system requests are served, alternating phases
// - mirror enable acts only once channel mapping is configured
// - pin select drives the interrupt on the error pin
// - non-maskable interrupt is sent only while its select bit is set
// - system management interrupt is sent only while its select bit is set
// - with both selects set only the system management interrupt goes out
`timescale 1ns/1ps
`include "psc_consts.svh"
module psc_patrol_scrub_control #(
  parameter int AW = 32,
  parameter int IW = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_ack,
  input wire logic [AW-1:0] range_last,
  output logic scrub_req,
  output logic [AW-1:0] scrub_req_addr,
  input wire logic scrub_resp,
  input wire logic resp_poison,
  input wire logic resp_uncorr,
  input wire logic conv_poison_en,
  output logic poison_convert,
  output logic err_log,
  output logic [AW-1:0] err_log_addr,
  input wire logic chan_map_valid,
  input wire logic spare_copy_active,
  output logic sys_req_block,
  output logic mirror_active,
  output logic err_pin_n,
  output logic nmi_req,
  output logic smi_req
);
  // ********************************************************
  // registers
  // ********************************************************
  logic [31:0] ctrl;
  logic [AW-1:0] scrub_addr;
  logic [2:0] route;
  logic [12:0] spare_len;
  logic [15:0] normal_len;
  logic mirror_en;
  logic [AW-1:0] cur_addr;
  psc_pkg::psc_state_t state;
  logic expired;

  function automatic logic hit(input logic [11:0] off);
    hit = cfg_wr && (cfg_addr == off);
  endfunction : hit

  logic scrub_en;
  logic stop_cmpl;
  logic stop_err;
  logic once;
  logic start;
  logic [IW-1:0] interval;
  assign scrub_en = ctrl[`PSC_B_EN];
  assign stop_cmpl = ctrl[`PSC_B_STOP_CMPL];
  assign stop_err = ctrl[`PSC_B_STOP_ERR];
  assign once = ctrl[`PSC_B_ONCE];
  assign start = ctrl[`PSC_B_START];
  assign interval = ctrl[`PSC_F_IVL_HI:0];

  // ********************************************************
  // engine decisions
  // ********************************************************
  logic issue;
  logic [AW-1:0] issue_addr;
  logic resp_err;
  logic err_halt;
  logic at_end;
  logic cmpl_set;
  logic halt_event;
  logic [AW-1:0] next_addr;

  // a request goes out only while enabled and the interval has run out
  assign issue = (state == psc_pkg::st_count) && scrub_en && expired;
  assign issue_addr = (start || once) ? scrub_addr : cur_addr;
  assign resp_err = (state == psc_pkg::st_wait) && scrub_resp && (resp_poison || resp_uncorr);
  assign err_halt = resp_err && stop_err;
  assign at_end = (scrub_addr == range_last);
  assign cmpl_set = (state == psc_pkg::st_wait) && scrub_resp && !err_halt && !once
                    && at_end && stop_cmpl;
  assign halt_event = err_halt || cmpl_set;
  assign next_addr = at_end ? '0 : scrub_addr + AW'(1);

  // ********************************************************
  // state machine
  // ********************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= psc_pkg::st_idle;
    end else begin
      unique case (state)
        psc_pkg::st_idle: begin
          if (scrub_en) begin
            state <= psc_pkg::st_count;
          end
        end
        psc_pkg::st_count: begin
          if (!scrub_en) begin
            state <= psc_pkg::st_idle;
          end else if (issue) begin
            state <= psc_pkg::st_wait;
          end
        end
        // the outstanding response is always collected, even if enable drops
        psc_pkg::st_wait: begin
          if (scrub_resp) begin
            if (err_halt) begin
              state <= psc_pkg::st_halt_err;
            end else if (once) begin
              state <= psc_pkg::st_once;
            end else if (cmpl_set) begin
              state <= psc_pkg::st_halt_cmpl;
            end else begin
              state <= scrub_en ? psc_pkg::st_count : psc_pkg::st_idle;
            end
          end
        end
        psc_pkg::st_halt_cmpl: begin
          if (!scrub_en) begin
            state <= psc_pkg::st_idle;
          end else if (!ctrl[`PSC_B_CMPL] || !stop_cmpl) begin
            state <= psc_pkg::st_count;
          end
        end
        psc_pkg::st_halt_err: begin
          if (!scrub_en) begin
            state <= psc_pkg::st_idle;
          end else if (!ctrl[`PSC_B_STOPPED] || !stop_err) begin
            state <= psc_pkg::st_count;
          end
        end
        psc_pkg::st_once: begin
          if (!scrub_en) begin
            state <= psc_pkg::st_idle;
          end else if (!once) begin
            state <= psc_pkg::st_count;
          end
        end
      endcase
    end
  end

  // next address is taken on every response, so an error halt resumes past it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_addr <= '0;
    end else if ((state == psc_pkg::st_wait) && scrub_resp) begin
      cur_addr <= next_addr;
    end
  end

  psc_interval_timer #(.W(IW)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(issue),
    .load(interval),
    .expired(expired)
  );

  // ********************************************************
  // control register and scrub address
  // ********************************************************
  // hardware sets win over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 32'h00000000;
    end else begin
      if (hit(`PSC_OFF_CTRL)) begin
        ctrl <= cfg_wdata;
      end
      if (issue && start && !hit(`PSC_OFF_CTRL)) begin
        ctrl[`PSC_B_START] <= 1'b0;
      end
      if (issue) begin
        ctrl[`PSC_B_ISSUED] <= 1'b1;
      end
      if (cmpl_set) begin
        ctrl[`PSC_B_CMPL] <= 1'b1;
      end
      if (err_halt) begin
        ctrl[`PSC_B_STOPPED] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scrub_addr <= '0;
    end else if (issue) begin
      scrub_addr <= issue_addr;
    end else if (hit(`PSC_OFF_ADDR)) begin
      scrub_addr <= cfg_wdata[AW-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      route <= 3'h0;
      spare_len <= `PSC_RST_SPARE_LEN;
      normal_len <= `PSC_RST_NORMAL_LEN;
      mirror_en <= 1'b0;
    end else begin
      if (hit(`PSC_OFF_ROUTE)) begin
        route <= cfg_wdata[`PSC_B_PIN:`PSC_B_SMI];
      end
      if (hit(`PSC_OFF_SPARE)) begin
        spare_len <= cfg_wdata[`PSC_F_SPR_HI:`PSC_F_SPR_LO];
        normal_len <= cfg_wdata[`PSC_F_NRM_HI:0];
      end
      if (hit(`PSC_OFF_RAS)) begin
        mirror_en <= cfg_wdata[`PSC_B_MIRROR];
      end
    end
  end

  // reads answer one cycle later; unmapped offsets read as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h00000000;
      cfg_rd_ack <= 1'b0;
    end else begin
      cfg_rd_ack <= cfg_rd;
      cfg_rdata <= 32'h00000000;
      if (cfg_rd) begin
        unique case (cfg_addr)
          `PSC_OFF_CTRL: cfg_rdata <= ctrl;
          `PSC_OFF_ADDR: cfg_rdata <= 32'(scrub_addr);
          `PSC_OFF_ROUTE: cfg_rdata <= {14'h0000, route, 15'h0000};
          `PSC_OFF_SPARE: cfg_rdata <= {3'h0, spare_len, normal_len};
          `PSC_OFF_RAS: cfg_rdata <= {31'h00000000, mirror_en};
          default: cfg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ********************************************************
  // memory side outputs
  // ********************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scrub_req <= 1'b0;
      scrub_req_addr <= '0;
    end else begin
      scrub_req <= issue;
      if (issue) begin
        scrub_req_addr <= issue_addr;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_log <= 1'b0;
      err_log_addr <= '0;
      poison_convert <= 1'b0;
    end else begin
      err_log <= resp_err;
      poison_convert <= err_halt && resp_uncorr && conv_poison_en;
      if (resp_err) begin
        err_log_addr <= scrub_addr;
      end
    end
  end

  psc_phase_alternator #(.SW(13), .NW(16)) u_phase (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .spare_active(spare_copy_active),
    .spare_len(spare_len),
    .normal_len(normal_len),
    .block_sys(sys_req_block)
  );

  // mirroring stays off until the channel map is valid
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mirror_active <= 1'b0;
    end else begin
      mirror_active <= mirror_en && chan_map_valid;
    end
  end

  // ********************************************************
  // interrupt routing of halt events
  // ********************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_pin_n <= 1'b1;
      nmi_req <= 1'b0;
      smi_req <= 1'b0;
    end else begin
      err_pin_n <= !(halt_event && route[2]);
      smi_req <= halt_event && route[0];
      nmi_req <= halt_event && route[1] && !route[0];
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  logic [IW-1:0] gap;
  logic seen_req;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= '0;
      seen_req <= 1'b0;
    end else begin
      seen_req <= seen_req || scrub_req;
      gap <= scrub_req ? IW'(1) : ((gap == '1) ? gap : gap + IW'(1));
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_req_needs_enable: assert property (scrub_req |-> $past(scrub_en))
    else $error("scrub request while disabled");
  a_cmpl_halt: assert property (cmpl_set |=> (ctrl[`PSC_B_CMPL] && !scrub_req) [*3])
    else $error("range end did not halt with complete set");
  a_cmpl_restart: assert property ((state == psc_pkg::st_halt_cmpl) && scrub_en
    && !ctrl[`PSC_B_CMPL] |=> (state == psc_pkg::st_count) && (cur_addr == '0))
    else $error("no restart from range start");
  a_err_logged: assert property (err_halt |=> err_log && (err_log_addr == $past(scrub_addr)))
    else $error("error not logged");
  a_conv_poison: assert property (err_halt && resp_uncorr && conv_poison_en |=> poison_convert)
    else $error("uncorrectable not converted");
  a_err_stopped: assert property (err_halt |=> ctrl[`PSC_B_STOPPED]
    && (state == psc_pkg::st_halt_err))
    else $error("error halt without stopped bit");
  a_err_resume: assert property ((state == psc_pkg::st_halt_err) && scrub_en
    && !(ctrl[`PSC_B_STOPPED] && stop_err)
    |=> (state == psc_pkg::st_count) && (cur_addr == $past(next_addr)))
    else $error("no resume at following address");
  a_issued_addr: assert property (issue |=> ctrl[`PSC_B_ISSUED]
    && (scrub_addr == $past(issue_addr)) && (scrub_req_addr == scrub_addr))
    else $error("issued address not logged");
  a_once_stops: assert property ((state == psc_pkg::st_once) |-> !scrub_req [*2])
    else $error("issue-once scrubbed twice");
  a_start_clear: assert property (issue && start && !hit(`PSC_OFF_CTRL) |=> !start)
    else $error("start bit not cleared");
  a_req_spacing: assert property (scrub_req && seen_req && $past(seen_req)
    |-> gap >= $past(interval, 2))
    else $error("requests closer than interval");
  a_smi_wins: assert property (halt_event && route[1] && route[0] |=> smi_req && !nmi_req)
    else $error("both selects must give only smi");
  a_pin_route: assert property (halt_event && route[2] |=> !err_pin_n ##1 err_pin_n)
    else $error("error pin not pulsed");

  c_range_halt: cover property (cmpl_set ##[1:100] (state == psc_pkg::st_count));
  c_err_resume: cover property (err_halt ##[1:100] scrub_req);
  c_once: cover property (issue && once);
  c_phase_flip: cover property ($rose(sys_req_block) ##[1:1000] $fell(sys_req_block));
endmodule : psc_patrol_scrub_control

// ==== tb/psc_dram_model.sv ====
// behavioural dram channel answering patrol scrub requests
`timescale 1ns/1ps
module psc_dram_model (
  input wire logic sys_clk,
  input wire logic scrub_req,
  input wire logic [1:0] bad_kind,
  output logic scrub_resp,
  output logic resp_poison,
  output logic resp_uncorr
);
  int cnt = 0;
  logic fire;
  initial begin
    scrub_resp = 1'b0;
    resp_poison = 1'b0;
    resp_uncorr = 1'b0;
  end
  // qualifiers toggle outside a response so a stale value never looks valid
  always @(negedge sys_clk) begin
    fire = 1'b0;
    if (scrub_req === 1'b1) begin
      cnt = 1 + $urandom % 6;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
      fire = (cnt == 0);
    end
    scrub_resp <= fire;
    resp_poison <= fire ? bad_kind[0] : ~resp_poison;
    resp_uncorr <= fire ? bad_kind[1] : ~resp_uncorr;
  end
endmodule : psc_dram_model

// ==== tb/psc_patrol_scrub_control_tb.sv ====
// self-checking bench for the patrol scrub control block
`timescale 1ns/1ps
`include "psc_consts.svh"
module psc_patrol_scrub_control_tb;
  localparam logic [31:0] EN = 32'h1 << `PSC_B_EN;
  localparam logic [31:0] SCMP = 32'h1 << `PSC_B_STOP_CMPL;
  localparam logic [31:0] CMP = 32'h1 << `PSC_B_CMPL;
  localparam logic [31:0] SERR = 32'h1 << `PSC_B_STOP_ERR;
  localparam logic [31:0] STP = 32'h1 << `PSC_B_STOPPED;
  localparam logic [31:0] ISS = 32'h1 << `PSC_B_ISSUED;
  localparam logic [31:0] ONCE = 32'h1 << `PSC_B_ONCE;
  localparam logic [31:0] STRT = 32'h1 << `PSC_B_START;
  localparam logic [31:0] IVL = {8'h00, `PSC_MIN_INTERVAL};
  logic sys_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, err_log_addr, scrub_req_addr;
  logic cfg_rd_ack, scrub_req, scrub_resp, resp_poison, resp_uncorr, poison_convert, err_log;
  logic conv_poison_en = 1'b0, chan_map_valid = 1'b0, spare_copy_active = 1'b0;
  logic sys_req_block, mirror_active, err_pin_n, nmi_req, smi_req;
  logic [1:0] bad_kind = 2'b00;
  int error_cnt = 0, samples_checked = 0, cyc = 0, last = -1;
  int n_req, n_log, n_conv, n_pin, n_nmi, n_smi, a, hi, lo;
  logic [31:0] exp_q[$];
  always #10 sys_clk = ~sys_clk;
  psc_patrol_scrub_control psc_patrol_scrub_control_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack), .range_last(32'h0000_0003),
    .scrub_req(scrub_req), .scrub_req_addr(scrub_req_addr), .scrub_resp(scrub_resp),
    .resp_poison(resp_poison), .resp_uncorr(resp_uncorr), .conv_poison_en(conv_poison_en),
    .poison_convert(poison_convert), .err_log(err_log), .err_log_addr(err_log_addr),
    .chan_map_valid(chan_map_valid), .spare_copy_active(spare_copy_active),
    .sys_req_block(sys_req_block), .mirror_active(mirror_active), .err_pin_n(err_pin_n),
    .nmi_req(nmi_req), .smi_req(smi_req));
  psc_dram_model psc_dram_model_inst (.sys_clk(sys_clk), .scrub_req(scrub_req),
    .bad_kind(bad_kind), .scrub_resp(scrub_resp), .resp_poison(resp_poison),
    .resp_uncorr(resp_uncorr));
  // ********************
  // helpers
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_addr = ad;
    cfg_wdata = d;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] ad, output logic [31:0] d);
    @(negedge sys_clk);
    cfg_rd = 1'b1;
    cfg_addr = ad;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    d = 32'hDEAD_BEEF;
    for (int i = 0; i < 4; i++) begin
      if (cfg_rd_ack === 1'b1) begin
        d = cfg_rdata;
        break;
      end
      @(negedge sys_clk);
    end
  endtask : rd
  task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
    logic [31:0] d;
    rd(ad, d);
    chk(d, e);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic clr();
    {n_req, n_log, n_conv, n_pin, n_nmi, n_smi} = '0;
    last = -1;
  endtask : clr
  task automatic wait_n(input int n);
    for (int i = 0; i < 8000 && n_req < n; i++) @(negedge sys_clk);
    chk(n_req, n);
  endtask : wait_n
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // ********************
  // result monitor against the address model
  // ********************
  always @(posedge sys_clk) begin
    cyc++;
    if (scrub_req === 1'b1) begin
      n_req++;
      if (last >= 0) chk(32'(cyc - last >= IVL), 32'h1);
      if (exp_q.size() > 0) chk(scrub_req_addr, exp_q.pop_front());
      else chk(scrub_req_addr, 32'hFFFF_FFFF);
      last = cyc;
    end
    n_log += int'(err_log === 1'b1);
    n_conv += int'(poison_convert === 1'b1);
    n_pin += int'(err_pin_n === 1'b0);
    n_nmi += int'(nmi_req === 1'b1);
    n_smi += int'(smi_req === 1'b1);
  end
  initial begin
    #(70000 * 20);
    error_cnt++;
    summarize();
  end
  // ********************
  // tests
  // ********************
  initial begin
    void'($urandom(32'h0480ec5a));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    rchk(`PSC_OFF_CTRL, 32'h0);
    rchk(`PSC_OFF_ROUTE, 32'h0);
    rchk(`PSC_OFF_RAS, 32'h0);
    rchk(`PSC_OFF_SPARE, {3'h0, `PSC_RST_SPARE_LEN, `PSC_RST_NORMAL_LEN});
    wr(12'h904, 32'hFFFF_FFFF);
    rchk(12'h904, 32'h0);
    $display("test reset done");
    clr();
    wr(`PSC_OFF_ROUTE, 32'h0002_8000);
    wr(`PSC_OFF_ADDR, 32'h1);
    exp_q = '{32'h1, 32'h2, 32'h3};
    wr(`PSC_OFF_CTRL, EN | SCMP | STRT | IVL);
    wait_n(3);
    idle(1700);
    chk(n_req, 3);
    rchk(`PSC_OFF_CTRL, EN | SCMP | CMP | ISS | IVL);
    rchk(`PSC_OFF_ADDR, 32'h3);
    chk(n_smi, 1);
    chk(n_pin, 1);
    exp_q.push_back(32'h0);
    wr(`PSC_OFF_CTRL, EN | SCMP | IVL);
    wait_n(4);
    wr(`PSC_OFF_CTRL, 32'h0);
    $display("test range end done");
    idle(20);
    clr();
    wr(`PSC_OFF_ROUTE, 32'h0003_8000);
    wr(`PSC_OFF_ADDR, 32'h2);
    bad_kind = 2'b01;
    exp_q.push_back(32'h2);
    wr(`PSC_OFF_CTRL, EN | SERR | STRT | IVL);
    wait_n(1);
    idle(30);
    bad_kind = 2'b00;
    chk(n_log, 1);
    chk(err_log_addr, 32'h2);
    rchk(`PSC_OFF_CTRL, EN | SERR | STP | ISS | IVL);
    chk({n_smi[15:0], n_nmi[15:0]}, 32'h0001_0000);
    chk(n_pin, 1);
    exp_q.push_back(32'h3);
    wr(`PSC_OFF_CTRL, EN | SERR | IVL);
    wait_n(2);
    wr(`PSC_OFF_CTRL, 32'h0);
    $display("test poison halt done");
    idle(20);
    clr();
    wr(`PSC_OFF_ROUTE, 32'h0001_0000);
    wr(`PSC_OFF_ADDR, 32'h0);
    conv_poison_en = 1'b1;
    bad_kind = 2'b10;
    exp_q.push_back(32'h0);
    wr(`PSC_OFF_CTRL, EN | SERR | STRT | IVL);
    wait_n(1);
    idle(30);
    bad_kind = 2'b00;
    chk(n_conv, 1);
    chk({n_smi[15:0], n_nmi[15:0]}, 32'h0000_0001);
    chk(n_pin, 0);
    wr(`PSC_OFF_CTRL, 32'h0);
    $display("test uncorrectable done");
    idle(20);
    clr();
    a = $urandom % 4;
    wr(`PSC_OFF_ADDR, 32'(a));
    exp_q.push_back(32'(a));
    wr(`PSC_OFF_CTRL, EN | ONCE | IVL);
    wait_n(1);
    idle(3200);
    chk(n_req, 1);
    wr(`PSC_OFF_CTRL, IVL);
    idle(1700);
    chk(n_req, 1);
    $display("test issue once done");
    wr(`PSC_OFF_RAS, 32'h1);
    idle(3);
    chk(32'(mirror_active), 32'h0);
    chan_map_valid = 1'b1;
    idle(3);
    chk(32'(mirror_active), 32'h1);
    rchk(`PSC_OFF_RAS, 32'h1);
    $display("test mirror done");
    wr(`PSC_OFF_SPARE, 32'h0003_0005);
    spare_copy_active = 1'b1;
    for (int i = 0; i < 40 && sys_req_block !== 1'b1; i++) idle(1);
    hi = 0;
    lo = 0;
    for (int i = 0; i < 40 && sys_req_block === 1'b1; i++) begin
      hi++;
      idle(1);
    end
    for (int i = 0; i < 40 && sys_req_block === 1'b0; i++) begin
      lo++;
      idle(1);
    end
    chk(hi, 3);
    chk(lo, 5);
    spare_copy_active = 1'b0;
    $display("test sparing phases done");
    summarize();
  end
endmodule : psc_patrol_scrub_control_tb
